// ===== src/on_off_ctrl_pkg.sv
// Purpose: constants and types for the on/off threshold controller
// Assumes: 50 MHz pclk, millisecond delay settings
// Notes: register offsets are byte addresses on a 32-bit apb
`default_nettype none
package on_off_ctrl_pkg;

  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int value_width = 16;
  localparam int delay_width = 16;
  localparam int clk_freq_hz = 50000000;
  localparam int tick_period_ms = 1;
  localparam int cycles_per_ms = clk_freq_hz / 1000 * tick_period_ms;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] lower_threshold_offset = 8'h04;
  localparam logic [7:0] upper_threshold_offset = 8'h08;
  localparam logic [7:0] hysteresis_offset = 8'h0c;
  localparam logic [7:0] on_delay_offset = 8'h10;
  localparam logic [7:0] off_delay_offset = 8'h14;
  localparam logic [7:0] status_offset = 8'h18;

  // ----------------------------------------
  // control field layout and resets
  // ----------------------------------------
  localparam int ctrl_type_lsb = 0;
  localparam int ctrl_hyst_bit = 3;
  localparam int ctrl_ext_bit = 4;
  localparam logic [4:0] ctrl_reset = 5'h00;
  localparam logic [15:0] value_reset = 16'h0000;
  localparam int status_out_bit = 0;
  localparam int status_cond_bit = 1;
  localparam int status_pend_bit = 2;

  typedef enum logic [2:0] {
    cmp_between,
    cmp_greater,
    cmp_smaller,
    cmp_out_of_range,
    cmp_equal,
    cmp_smaller_equal,
    cmp_greater_equal,
    cmp_not_equal
  } compare_type;

endpackage
`default_nettype wire

// ===== src/on_off_threshold_controller.sv
// Purpose: threshold on/off controller with delays and hysteresis, apb slave
// Assumes: unsigned process values, inputs synchronous to pclk
// Notes: settings come from registers or from the external inputs
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - eight compare types; only two use upper
// - output on when comparison holds, else off
// - off: time on condition, switch after on-delay
// - on: time off condition, switch after off-delay
// - both delays zero: switch immediately
// - hysteresis: turn on above threshold plus hysteresis
// - hysteresis: turn off below threshold minus hysteresis
// - delay timing starts after hysteresis crossing
// - delay settings count in milliseconds
module on_off_threshold_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] process_value_in,
  input wire logic [15:0] ext_lower_threshold,
  input wire logic [15:0] ext_upper_threshold,
  input wire logic [15:0] ext_threshold_hysteresis,
  input wire logic [15:0] ext_turn_on_delay,
  input wire logic [15:0] ext_turn_off_delay,
  output logic control_output
);

  // ----------------------------------------
  // comparison helpers
  // ----------------------------------------
  // raw compare with a bias added to or taken from the thresholds
  function automatic logic compare_fn(
    input logic [2:0] ctype,
    input logic [17:0] v,
    input logic [17:0] lo,
    input logic [17:0] hi
  );
    logic r;
    r = 1'b0;
    case (on_off_ctrl_pkg::compare_type'(ctype))
      on_off_ctrl_pkg::cmp_between: r = (v >= lo) && (v <= hi);
      on_off_ctrl_pkg::cmp_greater: r = v > lo;
      on_off_ctrl_pkg::cmp_smaller: r = v < lo;
      on_off_ctrl_pkg::cmp_out_of_range: r = (v < lo) || (v > hi);
      on_off_ctrl_pkg::cmp_equal: r = v == lo;
      on_off_ctrl_pkg::cmp_smaller_equal: r = v <= lo;
      on_off_ctrl_pkg::cmp_greater_equal: r = v >= lo;
      on_off_ctrl_pkg::cmp_not_equal: r = v != lo;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [15:0] lower_threshold_r, lower_threshold_nxt;
  logic [15:0] upper_threshold_r, upper_threshold_nxt;
  logic [15:0] hysteresis_r, hysteresis_nxt;
  logic [15:0] on_delay_r, on_delay_nxt;
  logic [15:0] off_delay_r, off_delay_nxt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] prdata_nxt;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  // every access completes in one cycle, so the slave never stalls
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      on_off_ctrl_pkg::ctrl_offset,
      on_off_ctrl_pkg::lower_threshold_offset,
      on_off_ctrl_pkg::upper_threshold_offset,
      on_off_ctrl_pkg::hysteresis_offset,
      on_off_ctrl_pkg::on_delay_offset,
      on_off_ctrl_pkg::off_delay_offset,
      on_off_ctrl_pkg::status_offset: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    ctrl_nxt = ctrl_r;
    lower_threshold_nxt = lower_threshold_r;
    upper_threshold_nxt = upper_threshold_r;
    hysteresis_nxt = hysteresis_r;
    on_delay_nxt = on_delay_r;
    off_delay_nxt = off_delay_r;
    if (wr_en) begin
      case (paddr)
        on_off_ctrl_pkg::ctrl_offset: ctrl_nxt = pwdata[4:0];
        on_off_ctrl_pkg::lower_threshold_offset: lower_threshold_nxt = pwdata[15:0];
        on_off_ctrl_pkg::upper_threshold_offset: upper_threshold_nxt = pwdata[15:0];
        on_off_ctrl_pkg::hysteresis_offset: hysteresis_nxt = pwdata[15:0];
        on_off_ctrl_pkg::on_delay_offset: on_delay_nxt = pwdata[15:0];
        on_off_ctrl_pkg::off_delay_offset: off_delay_nxt = pwdata[15:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= on_off_ctrl_pkg::ctrl_reset;
      lower_threshold_r <= on_off_ctrl_pkg::value_reset;
      upper_threshold_r <= on_off_ctrl_pkg::value_reset;
      hysteresis_r <= on_off_ctrl_pkg::value_reset;
      on_delay_r <= on_off_ctrl_pkg::value_reset;
      off_delay_r <= on_off_ctrl_pkg::value_reset;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      lower_threshold_r <= lower_threshold_nxt;
      upper_threshold_r <= upper_threshold_nxt;
      hysteresis_r <= hysteresis_nxt;
      on_delay_r <= on_delay_nxt;
      off_delay_r <= off_delay_nxt;
    end
  end

  // ----------------------------------------
  // effective settings
  // ----------------------------------------
  // external inputs replace the stored values, the hysteresis enable stays in ctrl
  logic use_ext;
  logic hyst_on;
  logic [2:0] ctype;
  logic [15:0] lo_eff, hi_eff, hys_eff, ton_eff, turn_off_delay_eff;

  assign use_ext = ctrl_r[on_off_ctrl_pkg::ctrl_ext_bit];
  assign hyst_on = ctrl_r[on_off_ctrl_pkg::ctrl_hyst_bit];
  assign ctype = ctrl_r[on_off_ctrl_pkg::ctrl_type_lsb +: 3];
  assign lo_eff = use_ext ? ext_lower_threshold : lower_threshold_r;
  assign hi_eff = use_ext ? ext_upper_threshold : upper_threshold_r;
  assign hys_eff = hyst_on ? (use_ext ? ext_threshold_hysteresis : hysteresis_r) : 16'h0000;
  assign ton_eff = use_ext ? ext_turn_on_delay : on_delay_r;
  assign turn_off_delay_eff = use_ext ? ext_turn_off_delay : off_delay_r;

  // ----------------------------------------
  // condition with hysteresis
  // ----------------------------------------
  logic [17:0] v_x, lo_x, hi_x, h_x;
  logic on_cond, off_cond, target;
  logic out_r, out_nxt;

  assign v_x = {2'b00, process_value_in} + 18'h08000 + 18'h08000;
  assign lo_x = {2'b00, lo_eff} + 18'h10000;
  assign hi_x = {2'b00, hi_eff} + 18'h10000;
  assign h_x = {2'b00, hys_eff};

  // offsets keep the biased thresholds away from wrap
  always_comb begin
    on_cond = compare_fn(ctype, v_x, lo_x, hi_x);
    off_cond = !on_cond;
    if (hyst_on) begin
      case (on_off_ctrl_pkg::compare_type'(ctype))
        on_off_ctrl_pkg::cmp_greater, on_off_ctrl_pkg::cmp_greater_equal: begin
          on_cond = compare_fn(ctype, v_x, lo_x + h_x, hi_x);
          off_cond = v_x < lo_x - h_x;
        end
        on_off_ctrl_pkg::cmp_smaller, on_off_ctrl_pkg::cmp_smaller_equal: begin
          on_cond = compare_fn(ctype, v_x, lo_x - h_x, hi_x);
          off_cond = v_x > lo_x + h_x;
        end
        on_off_ctrl_pkg::cmp_between: begin
          on_cond = compare_fn(ctype, v_x, lo_x + h_x, hi_x - h_x);
          off_cond = (v_x < lo_x - h_x) || (v_x > hi_x + h_x);
        end
        on_off_ctrl_pkg::cmp_out_of_range: begin
          on_cond = compare_fn(ctype, v_x, lo_x - h_x, hi_x + h_x);
          off_cond = (v_x > lo_x + h_x) && (v_x < hi_x - h_x);
        end
        default: begin
          on_cond = compare_fn(ctype, v_x, lo_x, hi_x);
          off_cond = !on_cond;
        end
      endcase
    end
  end

  // outside both bands the present state stands
  assign target = out_r ? !off_cond : on_cond;

  // ----------------------------------------
  // millisecond tick and delay timing
  // ----------------------------------------
  localparam logic [15:0] tick_last = 16'(on_off_ctrl_pkg::cycles_per_ms - 1);
  logic [15:0] pre_r, pre_nxt;
  logic [15:0] ms_r, ms_nxt;
  logic pend_r, pend_nxt;
  logic tick;
  logic [15:0] delay_sel;

  // prescaler restarts with each pending start, so delays are whole milliseconds
  assign tick = pre_r == tick_last;
  assign delay_sel = out_r ? turn_off_delay_eff : ton_eff;

  always_comb begin
    pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
    out_nxt = out_r;
    ms_nxt = ms_r;
    pend_nxt = pend_r;
    if (ton_eff == 16'h0000 && turn_off_delay_eff == 16'h0000) begin
      out_nxt = target;
      pend_nxt = 1'b0;
      ms_nxt = 16'h0000;
    end else if (target == out_r) begin
      pend_nxt = 1'b0;
      ms_nxt = 16'h0000;
    end else if (!pend_r) begin
      pend_nxt = 1'b1;
      ms_nxt = 16'h0000;
      pre_nxt = 16'h0000;
      if (delay_sel == 16'h0000) begin
        out_nxt = target;
        pend_nxt = 1'b0;
      end
    end else if (tick) begin
      if (ms_r + 16'h0001 >= delay_sel) begin
        out_nxt = target;
        pend_nxt = 1'b0;
        ms_nxt = 16'h0000;
      end else begin
        ms_nxt = ms_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 16'h0000;
      ms_r <= 16'h0000;
      pend_r <= 1'b0;
      out_r <= 1'b0;
    end else if (clk_en) begin
      pre_r <= pre_nxt;
      ms_r <= ms_nxt;
      pend_r <= pend_nxt;
      out_r <= out_nxt;
    end
  end

  assign control_output = out_r;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] prdata_r;
  logic [31:0] status_word;

  // status flags at their package positions, elapsed ms just above them
  always_comb begin
    status_word = 32'h00000000;
    status_word[on_off_ctrl_pkg::status_out_bit] = out_r;
    status_word[on_off_ctrl_pkg::status_cond_bit] = target;
    status_word[on_off_ctrl_pkg::status_pend_bit] = pend_r;
    status_word[on_off_ctrl_pkg::status_pend_bit + 1 +: 16] = ms_r;
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_en) begin
      case (paddr)
        on_off_ctrl_pkg::ctrl_offset: prdata_nxt = {27'h0, ctrl_r};
        on_off_ctrl_pkg::lower_threshold_offset: prdata_nxt = {16'h0, lower_threshold_r};
        on_off_ctrl_pkg::upper_threshold_offset: prdata_nxt = {16'h0, upper_threshold_r};
        on_off_ctrl_pkg::hysteresis_offset: prdata_nxt = {16'h0, hysteresis_r};
        on_off_ctrl_pkg::on_delay_offset: prdata_nxt = {16'h0, on_delay_r};
        on_off_ctrl_pkg::off_delay_offset: prdata_nxt = {16'h0, off_delay_r};
        on_off_ctrl_pkg::status_offset: prdata_nxt = status_word;
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (clk_en) begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

endmodule

`default_nettype wire

// ===== test/process_source.sv
// Purpose: process value source standing in for the plant sensor
// Assumes: bench sets the next value right after a rising edge
// Notes: value moves on a rising pclk edge, and clears to zero at once on reset
`timescale 1ns/1ps
`default_nettype none
module process_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] next_value,
  output logic [15:0] process_value_in
);
  // --------------------------------
  // sample and present
  // --------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      process_value_in <= 16'h0000;
    end else begin
      process_value_in <= next_value;
    end
  end
endmodule
`default_nettype wire

// ===== test/on_off_threshold_controller_monitor.sv
// Purpose: port checker for the on/off controller
// Assumes: zero wait state apb slave
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module on_off_threshold_controller_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic control_output
);
  logic mapped;
  assign mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'b00);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence read_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence bad_access;
    psel && penable && !mapped;
  endsequence
  // --------------------------------
  // bus checks
  // --------------------------------
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  a_read_unmapped_zero: assert property (read_setup ##1 bad_access |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without read");
  a_upper_zero: assert property (prdata[31:19] == 13'h0) else $error("upper read bits set");
  // --------------------------------
  // controller checks
  // --------------------------------
  a_frozen_output: assert property (!clk_en |=> $stable(control_output))
    else $error("output moved while frozen");
endmodule
bind on_off_threshold_controller on_off_threshold_controller_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .control_output(control_output)
);
`default_nettype wire

// ===== test/on_off_threshold_controller_tb.sv
// Purpose: self-checking bench for the on/off controller
// Assumes: zero wait state apb, partner drives the process value
// Notes: a 1 ms on delay makes the longest test
`timescale 1ns/1ps
`default_nettype none
module on_off_threshold_controller_tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, control_output, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pv, want, elo, ehi, ehy, eon, eoff;
  logic [15:0] hv [15] = '{16'h7, 16'h8, 16'h3, 16'h2, 16'h6, 16'h8, 16'h4, 16'h6, 16'h7,
    16'h15, 16'h17, 16'h13, 16'ha, 16'h4, 16'h2};
  logic [4:0] hc [15] = '{5'h9, 5'h9, 5'h9, 5'h9, 5'ha, 5'ha, 5'ha, 5'h8, 5'h8, 5'h8, 5'h8,
    5'hb, 5'hb, 5'hb, 5'hb};
  logic hx [15] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
    1'b1, 1'b0, 1'b0, 1'b1};
  int err_count, tests_run, lo, hi, v;
  on_off_threshold_controller dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .process_value_in(pv),
    .ext_lower_threshold(elo), .ext_upper_threshold(ehi), .ext_threshold_hysteresis(ehy),
    .ext_turn_on_delay(eon), .ext_turn_off_delay(eoff), .control_output(control_output));
  process_source src (.pclk(pclk), .presetn(presetn), .next_value(want),
    .process_value_in(pv));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setv(input logic [15:0] x, input int n);
    @(posedge pclk);
    want <= x;
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic expc(input int t, input int v, input int lo, input int hi);
    case (t)
      0: return v >= lo && v <= hi;
      1: return v > lo;
      2: return v < lo;
      3: return v < lo || v > hi;
      4: return v == lo;
      5: return v <= lo;
      6: return v >= lo;
      default: return v != lo;
    endcase
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge pclk);
    err_count++;
    tally_and_finish;
  end
  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    v = $urandom(32'h612fbd84);
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = 16'h0;
    elo = 16'h0064;
    ehi = 16'($urandom);
    ehy = 16'($urandom % 8);
    eon = 16'h0;
    eoff = 16'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 32'h18; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h3);
    for (int t = 0; t < 8; t++) begin
      repeat (4) begin
        lo = $urandom % 64;
        hi = lo + $urandom % 64;
        v = ($urandom % 2) ? $urandom % 128 : (($urandom % 2) ? lo : hi);
        apb(1'b1, 8'h00, 32'(t));
        apb(1'b1, 8'h04, 32'(lo));
        apb(1'b1, 8'h08, 32'(hi));
        setv(16'(v), 4);
        check({31'h0, control_output}, {31'h0, expc(t, v, lo, hi)});
      end
    end
    setv(16'h0, 1);
    apb(1'b1, 8'h00, 32'h9);
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h08, 32'h14);
    apb(1'b1, 8'h0c, 32'h2);
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, 8'h00, {27'h0, hc[i]});
      setv(hv[i], 4);
      check({31'h0, control_output}, {31'h0, hx[i]});
    end
    apb(1'b1, 8'h00, 32'h11);
    setv(16'h32, 4);
    check({31'h0, control_output}, 32'h0);
    clk_en <= 1'b0;
    setv(16'h65, 4);
    check({31'h0, control_output}, 32'h0);
    clk_en <= 1'b1;
    repeat (4) @(posedge pclk);
    check({31'h0, control_output}, 32'h1);
    setv(16'h0, 1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h10, 32'h1);
    setv(16'h6, 1000);
    check({31'h0, control_output}, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h6);
    setv(16'h0, 5);
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
    setv(16'h6, 49990);
    check({31'h0, control_output}, 32'h0);
    for (int i = 0; i < 30 && control_output !== 1'b1; i++) @(posedge pclk);
    check({31'h0, control_output}, 32'h1);
    setv(16'h0, 4);
    check({31'h0, control_output}, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
